/* File: cmic_pkg.sv */
// Purpose: shared constants and types for the mode/interrupt/cause logic
// Assumes: 32-bit apb data, one aligned word per register
// Notes: status and cause travel as packed structs in bit order
package cmic_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CAUSE = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_COMPARE = 8'h10;
  localparam logic [7:0] OFF_EXTIRQ = 8'h14;
  localparam logic [7:0] OFF_MODE = 8'h18;
  // writable bits; bits 23, 21 and 19 of status stay put
  localparam logic [31:0] STATUS_WMASK = 32'hff57_ffff;
  localparam logic [31:0] CAUSE_WMASK = 32'h0000_0300;
  // privilege field codes
  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] PRIV_SUPER = 2'h1;
  localparam logic [1:0] PRIV_USER = 2'h2;
  // exception codes
  localparam logic [4:0] EXC_INT = 5'h00;
  localparam logic [4:0] EXC_TLB_MOD = 5'h01;
  localparam logic [4:0] EXC_TLB_LOAD = 5'h02;
  localparam logic [4:0] EXC_TLB_STORE = 5'h03;
  localparam logic [4:0] EXC_ADDR_LOAD = 5'h04;
  localparam logic [4:0] EXC_ADDR_STORE = 5'h05;
  localparam logic [4:0] EXC_BUS_FETCH = 5'h06;
  localparam logic [4:0] EXC_BUS_DATA = 5'h07;
  localparam logic [4:0] EXC_SYSCALL = 5'h08;
  localparam logic [4:0] EXC_BREAK = 5'h09;
  localparam logic [4:0] EXC_RSV_INSTR = 5'h0a;
  localparam logic [4:0] EXC_COP_UNUSABLE = 5'h0b;
  localparam logic [4:0] EXC_OVERFLOW = 5'h0c;
  localparam logic [4:0] EXC_TRAP = 5'h0d;
  localparam logic [4:0] EXC_FLOAT = 5'h0f;
  localparam logic [4:0] EXC_WATCH = 5'h17;
  // reset values
  localparam logic CFG_BE_RESET = 1'b1;
  localparam logic [31:0] COMPARE_RESET = 32'hffff_ffff;

  typedef struct packed {
    logic [3:0] cu;
    logic reduced_power_bit;
    logic fr;
    logic reverse_endian_user;
    logic trace_support_enable;
    logic rsv23;
    logic bootstrap_vector_sel;
    logic tlb_shutdown_flag;
    logic soft_reset_flag;
    logic rsv19;
    logic ch;
    logic ce;
    logic de;
    logic [7:0] irq_mask;
    logic kernel_wide_addr;
    logic super_wide_enable;
    logic user_wide_enable;
    logic [1:0] privilege_field;
    logic error_level;
    logic exception_level;
    logic global_irq_enable;
  } cmic_status_t;

  typedef struct packed {
    logic branch_delay_flag;
    logic rsv30;
    logic [1:0] cop_unit;
    logic [11:0] rsv27_16;
    logic [7:0] irq_pending;
    logic rsv7;
    logic [4:0] exception_code;
    logic [1:0] rsv1_0;
  } cmic_cause_t;

  typedef enum logic [1:0] {
    MODE_KERNEL, MODE_SUPER, MODE_USER
  } cmic_mode_t;

  typedef enum logic {TR_IDLE, TR_BUSY} cmic_trace_t;
endpackage

/* File: cmic_sysctl_model.sv */
// Purpose: system controller that answers trace block reads
// Assumes: at most one trace read outstanding at a time
// Notes: answer latency is chosen by the bench for each read
`timescale 1ns/1ps
module cmic_sysctl_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // trace read side
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0] lat_i,
  // answer
  output logic resp_o,
  output logic [31:0] last_addr_o
);
  logic [3:0] cnt_q;

  // one-cycle answer pulse after lat_i request cycles; the request is held by the device until it sees it
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      resp_o <= 1'b0;
      last_addr_o <= 32'h0;
    end else if (req_i && !resp_o) begin
      cnt_q <= cnt_q + 4'h1;
      resp_o <= ((cnt_q + 4'h1) >= lat_i);
      last_addr_o <= addr_i;
    end else begin
      cnt_q <= 4'h0;
      resp_o <= 1'b0;
    end
  end
endmodule // cmic_sysctl_model

/* File: cmic_top.sv */
// Purpose: privilege modes, interrupt gating, cause and trace-read logic
// Assumes: apb slave, pipeline event inputs on mclk_i
// Notes: mode and width outputs lag status by one clock
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module cmic_top #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // interrupt sources
  input wire logic [4:0] int_pins_i,
  input wire logic ext_irq_wr_i,
  input wire logic [4:0] ext_irq_data_i,
  // reset events
  input wire logic soft_reset_i,
  input wire logic nmi_i,
  // pipeline events
  input wire logic exc_take_i,
  input wire logic [4:0] exc_code_i,
  input wire logic exc_delay_slot_i,
  input wire logic [1:0] exc_cop_unit_i,
  input wire logic branch_taken_i,
  input wire logic pc_jump_i,
  input wire logic [31:0] target_paddr_i,
  input wire logic tlb_multi_match_i,
  // trace block read
  input wire logic trace_resp_i,
  output logic trace_read_req_o,
  output logic [31:0] sys_addr_data_bus_o,
  output logic force_icache_miss_o,
  // mode and control state
  output logic irq_accept_o,
  output cmic_pkg::cmic_mode_t op_mode_o,
  output logic addr64_en_o,
  output logic op64_en_o,
  output logic kseg_ok_o,
  output logic sseg_ok_o,
  output logic useg_ok_o,
  output logic big_endian_o,
  output logic boot_vector_o,
  output logic shutdown_o
);

  cmic_pkg::cmic_status_t st_q;
  logic [1:0] ip_sw_q;
  logic ip_timer_q;
  logic [4:0] ext_wr_q;
  logic [4:0] int_meta_q;
  logic [4:0] int_sync_q;
  logic bd_q;
  logic [1:0] ce_q;
  logic [4:0] code_q;
  logic cfg_be_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] compare_q;
  cmic_pkg::cmic_trace_t tr_q;
  cmic_pkg::cmic_cause_t cause_v;
  cmic_pkg::cmic_mode_t mode_d;
  logic [31:0] rd_d;
  logic hit_d;
  logic wr_en;
  logic setup;
  logic trace_evt;
  logic [7:0] ip_v;

  function automatic cmic_pkg::cmic_mode_t mode_of(
    input cmic_pkg::cmic_status_t s);
    if (s.exception_level || s.error_level ||
        s.privilege_field == cmic_pkg::PRIV_KERNEL) begin
      return cmic_pkg::MODE_KERNEL;
    end else if (s.privilege_field == cmic_pkg::PRIV_SUPER) begin
      return cmic_pkg::MODE_SUPER;
    end else if (s.privilege_field == cmic_pkg::PRIV_USER) begin
      return cmic_pkg::MODE_USER;
    end
    // code 11 is undefined; treat it as the most privileged
    return cmic_pkg::MODE_KERNEL;
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old,
    input logic [31:0] nw, input logic [31:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
  assign mode_d = mode_of(st_q);
  // pending vector: timer, external, software
  assign ip_v = {ip_timer_q, int_sync_q | ext_wr_q, ip_sw_q};

  always_comb begin
    cause_v = '0;
    cause_v.branch_delay_flag = bd_q;
    cause_v.cop_unit = ce_q;
    cause_v.irq_pending = ip_v;
    cause_v.exception_code = code_q;
  end

  // read decode, sampled in the setup cycle
  always_comb begin
    rd_d = '0;
    hit_d = 1'b1;
    case (paddr_i)
      cmic_pkg::OFF_STATUS: rd_d = st_q;
      cmic_pkg::OFF_CAUSE: rd_d = cause_v;
      cmic_pkg::OFF_CONFIG: rd_d = {31'h0, cfg_be_q};
      cmic_pkg::OFF_COUNT: rd_d = 32'(count_q);
      cmic_pkg::OFF_COMPARE: rd_d = 32'(compare_q);
      cmic_pkg::OFF_EXTIRQ: rd_d = {27'h0, ext_wr_q};
      cmic_pkg::OFF_MODE: rd_d = {30'h0, mode_d};
      default: hit_d = 1'b0;
    endcase
  end

  // apb handshake: one access cycle, data and error from flops
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pready_o <= 1'b1;
      prdata_o <= pwrite_i ? 32'h0 : rd_d;
      pslverr_o <= !hit_d;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // status register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.error_level <= 1'b1;
      st_q.bootstrap_vector_sel <= 1'b1;
      st_q.soft_reset_flag <= 1'b0;
    end else if (soft_reset_i || nmi_i) begin
      st_q.error_level <= 1'b1;
      st_q.bootstrap_vector_sel <= 1'b1;
      st_q.reduced_power_bit <= 1'b0;
      st_q.tlb_shutdown_flag <= 1'b0;
      st_q.soft_reset_flag <= 1'b1;
    end else begin
      if (wr_en && paddr_i == cmic_pkg::OFF_STATUS) begin
        st_q <= wmask(st_q, pwdata_i, cmic_pkg::STATUS_WMASK);
      end
      if (exc_take_i) begin
        st_q.exception_level <= 1'b1;
      end
      // once set only a reset, a soft reset or an nmi clears it
      if (tlb_multi_match_i || st_q.tlb_shutdown_flag) begin
        st_q.tlb_shutdown_flag <= 1'b1;
      end
    end
  end

  // exception record
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bd_q <= 1'b0;
      ce_q <= '0;
      code_q <= cmic_pkg::EXC_INT;
    end else if (exc_take_i) begin
      bd_q <= exc_delay_slot_i;
      ce_q <= exc_cop_unit_i;
      code_q <= exc_code_i;
    end
  end

  // software pending bits, the only writable cause bits
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ip_sw_q <= '0;
    end else if (wr_en && paddr_i == cmic_pkg::OFF_CAUSE) begin
      ip_sw_q <= pwdata_i[9:8];
    end
  end

  // pin synchroniser
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      int_meta_q <= '0;
      int_sync_q <= '0;
    end else begin
      int_meta_q <= int_pins_i;
      int_sync_q <= int_meta_q;
    end
  end

  // external write requests; apb write clears bits, new request wins
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ext_wr_q <= '0;
    end else begin
      if (wr_en && paddr_i == cmic_pkg::OFF_EXTIRQ) begin
        ext_wr_q <= ext_wr_q & ~pwdata_i[4:0];
      end
      if (ext_irq_wr_i) begin
        ext_wr_q <= ext_irq_data_i;
      end
    end
  end

  // count and compare
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else if (wr_en && paddr_i == cmic_pkg::OFF_COUNT) begin
      count_q <= pwdata_i[CNT_W-1:0];
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      compare_q <= CNT_W'(cmic_pkg::COMPARE_RESET);
    end else if (wr_en && paddr_i == cmic_pkg::OFF_COMPARE) begin
      compare_q <= pwdata_i[CNT_W-1:0];
    end
  end

  // timer pending: a compare write clears, a match in that cycle wins
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ip_timer_q <= 1'b0;
    end else if (count_q == compare_q) begin
      ip_timer_q <= 1'b1;
    end else if (wr_en && paddr_i == cmic_pkg::OFF_COMPARE) begin
      ip_timer_q <= 1'b0;
    end
  end

  // endian config, big endian out of reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cfg_be_q <= cmic_pkg::CFG_BE_RESET;
    end else if (wr_en && paddr_i == cmic_pkg::OFF_CONFIG) begin
      cfg_be_q <= pwdata_i[0];
    end
  end

  // mode-derived outputs
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      op_mode_o <= cmic_pkg::MODE_KERNEL;
      addr64_en_o <= 1'b0;
      op64_en_o <= 1'b1;
      kseg_ok_o <= 1'b1;
      sseg_ok_o <= 1'b1;
      useg_ok_o <= 1'b1;
      big_endian_o <= cmic_pkg::CFG_BE_RESET;
    end else begin
      op_mode_o <= mode_d;
      unique case (mode_d)
        cmic_pkg::MODE_KERNEL: begin
          addr64_en_o <= st_q.kernel_wide_addr;
          op64_en_o <= 1'b1;
        end
        cmic_pkg::MODE_SUPER: begin
          addr64_en_o <= st_q.super_wide_enable;
          op64_en_o <= st_q.super_wide_enable;
        end
        cmic_pkg::MODE_USER: begin
          addr64_en_o <= st_q.user_wide_enable;
          op64_en_o <= st_q.user_wide_enable;
        end
      endcase
      kseg_ok_o <= mode_d == cmic_pkg::MODE_KERNEL;
      sseg_ok_o <= mode_d != cmic_pkg::MODE_USER;
      useg_ok_o <= 1'b1;
      big_endian_o <= cfg_be_q ^ (st_q.reverse_endian_user &&
        mode_d == cmic_pkg::MODE_USER);
    end
  end

  // interrupt gate and status mirrors
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_accept_o <= 1'b0;
      boot_vector_o <= 1'b1;
      shutdown_o <= 1'b0;
    end else begin
      irq_accept_o <= st_q.global_irq_enable && !st_q.exception_level &&
        !st_q.error_level && |(ip_v & st_q.irq_mask);
      boot_vector_o <= st_q.bootstrap_vector_sel;
      shutdown_o <= st_q.tlb_shutdown_flag;
    end
  end

  // trace: an event while busy still forces a miss but starts no second block read
  assign trace_evt = st_q.trace_support_enable &&
    (branch_taken_i || pc_jump_i || exc_take_i);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tr_q <= cmic_pkg::TR_IDLE;
      trace_read_req_o <= 1'b0;
      sys_addr_data_bus_o <= '0;
      force_icache_miss_o <= 1'b0;
    end else begin
      force_icache_miss_o <= trace_evt;
      unique case (tr_q)
        cmic_pkg::TR_IDLE: begin
          if (trace_evt) begin
            tr_q <= cmic_pkg::TR_BUSY;
            trace_read_req_o <= 1'b1;
            sys_addr_data_bus_o <= target_paddr_i;
          end
        end
        cmic_pkg::TR_BUSY: begin
          if (trace_resp_i) begin
            tr_q <= cmic_pkg::TR_IDLE;
            trace_read_req_o <= 1'b0;
          end
        end
      endcase
    end
  end

  property p_irq_gate;
    @(posedge mclk_i) disable iff (!rst_n_i)
    irq_accept_o |-> $past(st_q.global_irq_enable) &&
      !$past(st_q.exception_level) && !$past(st_q.error_level);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt accepted while gated");

  property p_user_mode;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_q.privilege_field == cmic_pkg::PRIV_USER &&
     !st_q.exception_level && !st_q.error_level)
    |=> op_mode_o == cmic_pkg::MODE_USER;
  endproperty
  a_user_mode: assert property (p_user_mode)
    else $error("user mode not decoded");

  property p_super_mode;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_q.privilege_field == cmic_pkg::PRIV_SUPER &&
     !st_q.exception_level && !st_q.error_level)
    |=> op_mode_o == cmic_pkg::MODE_SUPER && sseg_ok_o && !kseg_ok_o;
  endproperty
  a_super_mode: assert property (p_super_mode)
    else $error("supervisor mode not decoded");

  property p_kernel_mode;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_q.exception_level || st_q.error_level ||
     st_q.privilege_field == cmic_pkg::PRIV_KERNEL)
    |=> op_mode_o == cmic_pkg::MODE_KERNEL && op64_en_o && kseg_ok_o;
  endproperty
  a_kernel_mode: assert property (p_kernel_mode)
    else $error("kernel mode not decoded");

  property p_trace_start;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (tr_q == cmic_pkg::TR_IDLE && trace_evt)
    |=> trace_read_req_o && force_icache_miss_o &&
      sys_addr_data_bus_o == $past(target_paddr_i);
  endproperty
  a_trace_start: assert property (p_trace_start)
    else $error("trace miss did not issue block read");

  property p_trace_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (trace_read_req_o && !trace_resp_i)
    |=> trace_read_req_o && $stable(sys_addr_data_bus_o);
  endproperty
  a_trace_hold: assert property (p_trace_hold)
    else $error("trace request dropped before response");

  property p_reset_vals;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> st_q.error_level && st_q.bootstrap_vector_sel &&
      !st_q.tlb_shutdown_flag && !st_q.reduced_power_bit &&
      !st_q.soft_reset_flag && cfg_be_q;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("status reset values wrong");

  property p_soft_flag;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (soft_reset_i || nmi_i) |=> st_q.soft_reset_flag && st_q.error_level;
  endproperty
  a_soft_flag: assert property (p_soft_flag)
    else $error("soft reset flag not set");

  property p_endian;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_q.reverse_endian_user && mode_d == cmic_pkg::MODE_USER)
    |=> big_endian_o == !$past(cfg_be_q);
  endproperty
  a_endian: assert property (p_endian)
    else $error("user byte order not reversed");

  property p_timer;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (count_q == compare_q) |=> ip_timer_q [*2];
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer pending not set on match");

  property p_shutdown;
    @(posedge mclk_i) disable iff (!rst_n_i)
    tlb_multi_match_i && !soft_reset_i && !nmi_i
    |=> st_q.tlb_shutdown_flag ##1 shutdown_o;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown flag not raised");

endmodule // cmic_top

/* File: tb_cmic_top.sv */
// Purpose: self-checking bench for the mode, interrupt, cause and trace logic
// Assumes: apb answers within a few cycles; trace reads answered by model
// Notes: random stimulus from a fixed seed plus hand-picked corners
`timescale 1ns/1ps
module tb_cmic_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, erv;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, target_paddr_i = 32'h0;
  logic [31:0] prdata_o, sys_addr_data_bus_o, last_addr, rdv;
  logic ext_irq_wr_i = 0, soft_reset_i = 0, nmi_i = 0, exc_take_i = 0;
  logic exc_delay_slot_i = 0, branch_taken_i = 0, pc_jump_i = 0;
  logic tlb_multi_match_i = 0, trace_resp_i, trace_read_req_o;
  logic pready_o, pslverr_o, force_icache_miss_o, irq_accept_o;
  logic addr64_en_o, op64_en_o, kseg_ok_o, sseg_ok_o, useg_ok_o;
  logic big_endian_o, boot_vector_o, shutdown_o;
  logic [4:0] int_pins_i = 0, ext_irq_data_i = 0, exc_code_i = 0;
  logic [1:0] exc_cop_unit_i = 0;
  logic [3:0] lat = 4'h1;
  cmic_pkg::cmic_mode_t op_mode_o;
  localparam cmic_pkg::cmic_mode_t mk = cmic_pkg::MODE_KERNEL;
  localparam cmic_pkg::cmic_mode_t ms = cmic_pkg::MODE_SUPER;
  localparam cmic_pkg::cmic_mode_t mu = cmic_pkg::MODE_USER;
  int fail_count = 0;
  int n_tests = 0;

  always #10 mclk_i = ~mclk_i;

  cmic_top dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .int_pins_i(int_pins_i),
    .ext_irq_wr_i(ext_irq_wr_i), .ext_irq_data_i(ext_irq_data_i),
    .soft_reset_i(soft_reset_i), .nmi_i(nmi_i), .exc_take_i(exc_take_i),
    .exc_code_i(exc_code_i), .exc_delay_slot_i(exc_delay_slot_i),
    .exc_cop_unit_i(exc_cop_unit_i), .branch_taken_i(branch_taken_i),
    .pc_jump_i(pc_jump_i), .target_paddr_i(target_paddr_i),
    .tlb_multi_match_i(tlb_multi_match_i), .trace_resp_i(trace_resp_i),
    .trace_read_req_o(trace_read_req_o),
    .sys_addr_data_bus_o(sys_addr_data_bus_o),
    .force_icache_miss_o(force_icache_miss_o),
    .irq_accept_o(irq_accept_o), .op_mode_o(op_mode_o),
    .addr64_en_o(addr64_en_o), .op64_en_o(op64_en_o),
    .kseg_ok_o(kseg_ok_o), .sseg_ok_o(sseg_ok_o), .useg_ok_o(useg_ok_o),
    .big_endian_o(big_endian_o), .boot_vector_o(boot_vector_o),
    .shutdown_o(shutdown_o)
  );

  cmic_sysctl_model ctl (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(trace_read_req_o),
    .addr_i(sys_addr_data_bus_o), .lat_i(lat), .resp_o(trace_resp_i),
    .last_addr_o(last_addr)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // setup at one edge, access until pready is high at a rising edge;
  // data taken and request released at that very edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) fail_count++;
    rdv = prdata_o;
    erv = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e & m, rdv & m);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  // one-cycle pulse on the chosen event input
  task automatic fire(input int k, input logic [31:0] tgt);
    @(posedge mclk_i);
    target_paddr_i <= tgt;
    case (k)
      0: branch_taken_i <= 1'b1;
      1: pc_jump_i <= 1'b1;
      2: exc_take_i <= 1'b1;
      3: tlb_multi_match_i <= 1'b1;
      4: soft_reset_i <= 1'b1;
      5: nmi_i <= 1'b1;
      default: ext_irq_wr_i <= 1'b1;
    endcase
    @(posedge mclk_i);
    {branch_taken_i, pc_jump_i, exc_take_i, tlb_multi_match_i} <= 4'h0;
    {soft_reset_i, nmi_i, ext_irq_wr_i} <= 3'h0;
  endtask

  task automatic waitmiss();
    int n = 0;
    @(negedge mclk_i);
    while (force_icache_miss_o !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    chk("miss", 1, force_icache_miss_o);
  endtask

  function automatic cmic_pkg::cmic_mode_t exp_mode(input logic [31:0] s);
    if (s[2] || s[1] || s[4:3] == 2'h0 || s[4:3] == 2'h3) return mk;
    return (s[4:3] == 2'h1) ? ms : mu;
  endfunction

  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    complete_run();
  end

  initial begin
    logic [31:0] s, sw, t, t2;
    cmic_pkg::cmic_mode_t m;
    static logic [4:0] codes [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
      5'h05,
      5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0f, 5'h17};
    int n;
    void'($urandom(36));
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    settle(0);
    chk("big_endian", 1, big_endian_o);
    chk("boot_vector", 1, boot_vector_o);
    chk("mode", {30'h0, mk}, {30'h0, op_mode_o});
    rdchk("status", cmic_pkg::OFF_STATUS, '1, 32'h0040_0004);
    wr(cmic_pkg::OFF_CAUSE, '1);
    rdchk("cause_ro", cmic_pkg::OFF_CAUSE, '1, 32'h0000_0300);
    for (int i = 0; i < 16; i++) begin
      s = $urandom & cmic_pkg::STATUS_WMASK & 32'hfeff_ffff;
      s[4:3] = i[1:0];
      if (i < 8) s[2:1] = 2'h0;
      sw = ($urandom & 32'h3) << 8;
      t = $urandom;
      wr(cmic_pkg::OFF_CONFIG, {31'h0, t[0]});
      wr(cmic_pkg::OFF_CAUSE, sw);
      wr(cmic_pkg::OFF_STATUS, s);
      settle(3);
      m = exp_mode(s);
      chk("mode", {30'h0, m}, {30'h0, op_mode_o});
      chk("addr64", (m == mk) ? s[7] : (m == ms) ? s[6] : s[5],
          addr64_en_o);
      chk("op64", (m == mk) | (m == ms & s[6]) | (m == mu & s[5]),
          op64_en_o);
      chk("segs", {m == mk, m != mu, 1'b1},
          {kseg_ok_o, sseg_ok_o, useg_ok_o});
      chk("endian", t[0] ^ (s[25] & (m == mu)), big_endian_o);
      chk("irq", s[0] & ~s[1] & ~s[2] & |(s[15:8] & sw[15:8]),
          irq_accept_o);
      chk("boot_vector", s[22], boot_vector_o);
      rdchk("status", cmic_pkg::OFF_STATUS, '1, s);
      rdchk("cause", cmic_pkg::OFF_CAUSE, '1, sw);
    end
    foreach (codes[i]) begin
      t = $urandom;
      exc_code_i <= codes[i];
      exc_delay_slot_i <= t[0];
      exc_cop_unit_i <= t[2:1];
      fire(2, 32'h0);
      rdchk("cause_exc", cmic_pkg::OFF_CAUSE, 32'hb000_007c,
            {t[0], 1'b0, t[2:1], 21'h0, codes[i], 2'h0});
    end
    chk("mode_exc", {30'h0, mk}, {30'h0, op_mode_o});
    wr(cmic_pkg::OFF_STATUS, 32'h0100_0000);
    for (int k = 0; k < 4; k++) begin
      t = $urandom;
      lat <= (k == 1) ? 4'h9 : 4'h2;
      fire(k % 3, t);
      waitmiss();
      chk("trace_req", 1, trace_read_req_o);
      chk("sys_bus", t, sys_addr_data_bus_o);
      if (k == 1) begin
        fire(0, ~t);
        waitmiss();
        chk("sys_bus_busy", t, sys_addr_data_bus_o);
      end
      n = 0;
      while (trace_read_req_o !== 1'b0 && n < 40) begin
        @(negedge mclk_i);
        n++;
      end
      chk("trace_done", 0, trace_read_req_o);
      chk("sys_seen", t, last_addr);
    end
    wr(cmic_pkg::OFF_STATUS, 32'h0);
    fire(0, 32'h0);
    t2 = 32'h0;
    repeat (4) begin
      @(negedge mclk_i);
      t2[0] = t2[0] | force_icache_miss_o;
    end
    chk("miss_off", 0, t2);
    wr(cmic_pkg::OFF_COUNT, 32'h0);
    wr(cmic_pkg::OFF_COMPARE, 32'h0000_0028);
    settle(50);
    rdchk("timer", cmic_pkg::OFF_CAUSE, 32'h8000, 32'h8000);
    wr(cmic_pkg::OFF_COMPARE, '1);
    rdchk("timer_clr", cmic_pkg::OFF_CAUSE, 32'h8000, 32'h0);
    t = $urandom | 32'h1;
    t2 = $urandom | 32'h10;
    int_pins_i <= t[4:0];
    settle(5);
    rdchk("pins", cmic_pkg::OFF_CAUSE, 32'h7c00, t << 10);
    int_pins_i <= 5'h0;
    ext_irq_data_i <= t2[4:0];
    fire(6, 32'h0);
    settle(4);
    rdchk("ext_wr", cmic_pkg::OFF_CAUSE, 32'h7c00, t2 << 10);
    wr(cmic_pkg::OFF_EXTIRQ, '1);
    rdchk("ext_clr", cmic_pkg::OFF_CAUSE, 32'h7c00, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 1, erv);
    chk("rd_unmapped", 0, rdv);
    fire(3, 32'h0);
    settle(1);
    chk("shutdown", 1, shutdown_o);
    wr(cmic_pkg::OFF_STATUS, 32'h0);
    rdchk("ts", cmic_pkg::OFF_STATUS, '1, 32'h0020_0000);
    for (int k = 4; k < 6; k++) begin
      fire(k, 32'h0);
      rdchk("soft", cmic_pkg::OFF_STATUS, '1, 32'h0050_0004);
      wr(cmic_pkg::OFF_STATUS, 32'h0);
    end
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rdchk("cold", cmic_pkg::OFF_STATUS, '1, 32'h0040_0004);
    complete_run();
  end
endmodule // tb_cmic_top
